// ---- design/lpddr_seq_pkg.sv ----
// Behaviour
// - Refresh or mode load only when all idle
// - Burst terminate hits only the bursting bank; the device returns every reading or writing bank to active
// - Unlisted bank-state/command pairs are never issued; host and device do not check them
// - Write after read needs completion or terminate
// - Read interrupting write masks pending data
// - Power-down kind follows open rows or last command
// - No power-down entry during column access
// - One rising clock during power-down exit
// - Only idle commands, clock enable high, during refresh
// - A10 high precharges all banks
// - Data and strobe float, mask ignored in refresh
// - Clock stable before leaving self refresh
// - All banks idle before self refresh
// - Idle commands for self-refresh exit, two clocks
// - Precharge after read waits minimum row-active time
// - Terminate with clock enable low enters deep power-down
// - Deep power-down lasts at least 100 us
// - Clock enable high leaves deep power-down
// - Wait, precharge, two refreshes, mode loads after exit
// - Auto-precharge variants share plain variant legality
// - Command encoding on select and three strobes
// - Other banks usable during auto-precharge access
package lpddr_seq_pkg;
   localparam real CLK_NS = 8.0;
   localparam real DPD_MIN_US = 100.0;
   localparam real DPD_INIT_US = 200.0;
   localparam int DPD_MIN_CYC = int'($ceil(DPD_MIN_US * 1000.0 / CLK_NS));
   localparam int DPD_INIT_CYC = int'($ceil(DPD_INIT_US * 1000.0 / CLK_NS));
   localparam int REFRESH_CYC = 9;
   localparam int XSR_CYC = 2;
   localparam int PDX_CYC = 1;
   localparam int RAS_CYC = 6;
   localparam int BURST_CYC = 2;
   localparam int INIT_REFRESHES = 2;
   localparam int BANKS = 4;
   localparam int A10_BIT = 10;
   localparam int ADDR_W = 13;
   // Encoding of {ras_n, cas_n, we_n} with select low.
   typedef enum logic [3:0] {
      CMD_DESELECT = 4'h8,
      CMD_NOP = 4'h7,
      CMD_ACTIVATE = 4'h3,
      CMD_READ = 4'h5,
      CMD_WRITE = 4'h4,
      CMD_PRECHARGE = 4'h2,
      CMD_REFRESH = 4'h1,
      CMD_LOAD_MODE = 4'h0,
      CMD_TERMINATE = 4'h6
   } cmd_t;
   typedef enum logic [2:0] {
      BANK_IDLE = 3'h0,
      BANK_ACTIVATING = 3'h1,
      BANK_ACTIVE = 3'h2,
      BANK_READING = 3'h3,
      BANK_WRITING = 3'h4,
      BANK_PRECHARGING = 3'h5
   } bank_t;
   typedef enum logic [2:0] {
      PWR_ON = 3'h0,
      PWR_PRE_PD = 3'h1,
      PWR_ACT_PD = 3'h2,
      PWR_SELF_REFRESH = 3'h3,
      PWR_DEEP_PD = 3'h4,
      PWR_REFRESHING = 3'h5
   } pwr_t;
   // Controller sequencer phases.
   typedef enum logic [3:0] {
      HOST_IDLE = 4'h0,
      HOST_WAIT = 4'h1,
      HOST_DPD = 4'h2,
      HOST_INIT_WAIT = 4'h3,
      HOST_INIT_PRE = 4'h4,
      HOST_INIT_REF = 4'h5,
      HOST_INIT_MODE = 4'h6,
      HOST_INIT_EMODE = 4'h7,
      HOST_PD = 4'h8,
      HOST_SR = 4'h9
   } host_t;
endpackage

// ---- design/lpddr_cmd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lpddr_cmd_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic [12:0] addr;
   logic dm;
   logic dq_oe_n;
   logic dqs_oe_n;
   modport device (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
      output dq_oe_n, dqs_oe_n);
   modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
      input dq_oe_n, dqs_oe_n);
endinterface
`default_nettype wire

// ---- design/lpddr_device_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpddr_device_seq #(
   parameter int DPD_MIN = lpddr_seq_pkg::DPD_MIN_CYC,
   parameter int REFRESH = lpddr_seq_pkg::REFRESH_CYC
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Command pins.
   lpddr_cmd_if.device link,
   // State view.
   output logic [2:0] power_state_out,
   output logic [11:0] bank_state_out,
   output logic illegal_out,
   output logic dpd_early_exit_out
);
   logic [2:0] bank [4];
   logic [3:0] ap;
   logic [3:0] tmr [4];
   logic cke_q;
   logic [31:0] dpd_cnt;
   logic [31:0] ref_cnt;
   lpddr_seq_pkg::cmd_t cmd;
   lpddr_seq_pkg::pwr_t pwr;
   logic any_open;
   logic all_idle;
   logic col_busy;
   logic last_act;

   function automatic lpddr_seq_pkg::cmd_t decode(input logic cs_n,
      input logic r, input logic c, input logic w);
      if (cs_n) begin
         return lpddr_seq_pkg::CMD_DESELECT;
      end
      return lpddr_seq_pkg::cmd_t'({1'b0, r, c, w});
   endfunction

   always_comb begin
      cmd = decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
      any_open = 1'b0;
      all_idle = 1'b1;
      col_busy = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (bank[i] != lpddr_seq_pkg::BANK_IDLE) begin
            all_idle = 1'b0;
         end
         if (bank[i] != lpddr_seq_pkg::BANK_IDLE &&
            bank[i] != lpddr_seq_pkg::BANK_PRECHARGING) begin
            any_open = 1'b1;
         end
         if (bank[i] == lpddr_seq_pkg::BANK_READING ||
            bank[i] == lpddr_seq_pkg::BANK_WRITING) begin
            col_busy = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      cke_q <= rst_in ? 1'b1 : link.cke;
   end

   // Per-bank tracking; commands only count while clock enable holds.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 4; i++) begin
            bank[i] <= lpddr_seq_pkg::BANK_IDLE;
            tmr[i] <= 4'h0;
         end
         ap <= 4'h0;
         last_act <= 1'b0;
      end else if (pwr == lpddr_seq_pkg::PWR_ON && cke_q && link.cke) begin
         for (int i = 0; i < 4; i++) begin
            if (tmr[i] != 4'h0) begin
               tmr[i] <= tmr[i] - 4'h1;
            end else if (bank[i] == lpddr_seq_pkg::BANK_ACTIVATING) begin
               bank[i] <= lpddr_seq_pkg::BANK_ACTIVE;
            end else if (bank[i] == lpddr_seq_pkg::BANK_PRECHARGING) begin
               bank[i] <= lpddr_seq_pkg::BANK_IDLE;
            end else if (bank[i] == lpddr_seq_pkg::BANK_READING ||
               bank[i] == lpddr_seq_pkg::BANK_WRITING) begin
               // Auto precharge closes the row itself.
               bank[i] <= ap[i] ? lpddr_seq_pkg::BANK_PRECHARGING :
                  lpddr_seq_pkg::BANK_ACTIVE;
               tmr[i] <= ap[i] ? 4'h1 : 4'h0;
            end
         end
         if (cmd != lpddr_seq_pkg::CMD_NOP &&
            cmd != lpddr_seq_pkg::CMD_DESELECT) begin
            last_act <= (cmd == lpddr_seq_pkg::CMD_ACTIVATE);
         end
         case (cmd)
            lpddr_seq_pkg::CMD_ACTIVATE: begin
               bank[link.ba] <= lpddr_seq_pkg::BANK_ACTIVATING;
               tmr[link.ba] <= 4'h1;
            end
            lpddr_seq_pkg::CMD_READ, lpddr_seq_pkg::CMD_WRITE: begin
               bank[link.ba] <= (cmd == lpddr_seq_pkg::CMD_READ) ?
                  lpddr_seq_pkg::BANK_READING : lpddr_seq_pkg::BANK_WRITING;
               ap[link.ba] <= link.addr[lpddr_seq_pkg::A10_BIT];
               tmr[link.ba] <= 4'(lpddr_seq_pkg::BURST_CYC - 1);
            end
            lpddr_seq_pkg::CMD_PRECHARGE: begin
               for (int i = 0; i < 4; i++) begin
                  if (link.addr[lpddr_seq_pkg::A10_BIT] || link.ba == 2'(i))
                  begin
                     bank[i] <= lpddr_seq_pkg::BANK_PRECHARGING;
                     tmr[i] <= 4'h1;
                  end
               end
            end
            lpddr_seq_pkg::CMD_TERMINATE: begin
               for (int i = 0; i < 4; i++) begin
                  if (bank[i] == lpddr_seq_pkg::BANK_READING ||
                     bank[i] == lpddr_seq_pkg::BANK_WRITING) begin
                     bank[i] <= lpddr_seq_pkg::BANK_ACTIVE;
                     tmr[i] <= 4'h0;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Power-down states entered on the falling clock enable edge; refreshing on a refresh command with clock enable held.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pwr <= lpddr_seq_pkg::PWR_ON;
         dpd_cnt <= 32'h0000_0000;
         ref_cnt <= 32'h0000_0000;
      end else begin
         case (pwr)
            lpddr_seq_pkg::PWR_ON: begin
               if (cke_q && link.cke && cmd == lpddr_seq_pkg::CMD_REFRESH)
               begin
                  pwr <= lpddr_seq_pkg::PWR_REFRESHING;
                  ref_cnt <= 32'(REFRESH - 1);
               end else if (cke_q && !link.cke) begin
                  if (cmd == lpddr_seq_pkg::CMD_TERMINATE) begin
                     pwr <= lpddr_seq_pkg::PWR_DEEP_PD;
                     dpd_cnt <= 32'h0000_0000;
                  end else if (cmd == lpddr_seq_pkg::CMD_REFRESH) begin
                     pwr <= lpddr_seq_pkg::PWR_SELF_REFRESH;
                  end else if (any_open || last_act) begin
                     pwr <= lpddr_seq_pkg::PWR_ACT_PD;
                  end else begin
                     pwr <= lpddr_seq_pkg::PWR_PRE_PD;
                  end
               end
            end
            lpddr_seq_pkg::PWR_REFRESHING: begin
               ref_cnt <= ref_cnt - 32'h0000_0001;
               if (ref_cnt == 32'h0000_0000) begin
                  pwr <= lpddr_seq_pkg::PWR_ON;
               end
            end
            lpddr_seq_pkg::PWR_DEEP_PD: begin
               if (dpd_cnt != 32'hFFFF_FFFF) begin
                  dpd_cnt <= dpd_cnt + 32'h0000_0001;
               end
               if (link.cke) begin
                  pwr <= lpddr_seq_pkg::PWR_ON;
               end
            end
            default: begin
               if (link.cke) begin
                  pwr <= lpddr_seq_pkg::PWR_ON;
               end
            end
         endcase
      end
   end

   // Flags are set once per faulting cycle, so counting them counts faulty cycles.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         illegal_out <= 1'b0;
         dpd_early_exit_out <= 1'b0;
      end else begin
         dpd_early_exit_out <= pwr == lpddr_seq_pkg::PWR_DEEP_PD &&
            link.cke && dpd_cnt < 32'(DPD_MIN);
         illegal_out <= (cke_q && pwr == lpddr_seq_pkg::PWR_ON &&
            (cmd == lpddr_seq_pkg::CMD_REFRESH ||
            cmd == lpddr_seq_pkg::CMD_LOAD_MODE) && !all_idle) ||
            (cke_q && !link.cke && col_busy) ||
            (pwr == lpddr_seq_pkg::PWR_REFRESHING && (!link.cke ||
            (cmd != lpddr_seq_pkg::CMD_NOP &&
            cmd != lpddr_seq_pkg::CMD_DESELECT)));
      end
   end

   always_comb begin
      power_state_out = pwr;
      for (int i = 0; i < 4; i++) begin
         bank_state_out[3 * i +: 3] = bank[i];
      end
      // Reads are modelled at command level only, so outputs float.
      link.dq_oe_n = 1'b1;
      link.dqs_oe_n = 1'b1;
   end
endmodule
`default_nettype wire

// ---- design/lpddr_host_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpddr_host_seq #(
   parameter int DPD_MIN = lpddr_seq_pkg::DPD_MIN_CYC,
   parameter int DPD_INIT = lpddr_seq_pkg::DPD_INIT_CYC,
   parameter int REFRESH = lpddr_seq_pkg::REFRESH_CYC
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // User requests, one-cycle pulses.
   input wire logic req_valid_in,
   input wire lpddr_seq_pkg::cmd_t req_cmd_in,
   input wire logic [1:0] req_bank_in,
   input wire logic [12:0] req_addr_in,
   input wire logic pd_req_in,
   input wire logic sr_req_in,
   input wire logic dpd_req_in,
   input wire logic wake_in,
   output logic req_ready_out,
   output logic busy_out,
   // Command pins.
   lpddr_cmd_if.host link
);
   lpddr_seq_pkg::host_t st;
   logic [31:0] cnt;
   logic [1:0] refs;
   logic [3:0] cmd_bits;
   logic [3:0] open_rows;

   // Every user command waits REFRESH cycles, so ordering gaps
   // such as refresh time and row-active time are covered coarsely.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= lpddr_seq_pkg::HOST_IDLE;
         cnt <= 32'h0000_0000;
         refs <= 2'h0;
         link.cke <= 1'b1;
         cmd_bits <= lpddr_seq_pkg::CMD_NOP;
         link.ba <= 2'h0;
         link.addr <= 13'h0000;
         open_rows <= 4'h0;
      end else begin
         cmd_bits <= lpddr_seq_pkg::CMD_NOP;
         if (cnt != 32'h0000_0000) begin
            cnt <= cnt - 32'h0000_0001;
         end
         case (st)
            lpddr_seq_pkg::HOST_IDLE: begin
               if (dpd_req_in && open_rows == 4'h0) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_TERMINATE;
                  link.cke <= 1'b0;
                  cnt <= 32'(DPD_MIN);
                  st <= lpddr_seq_pkg::HOST_DPD;
               end else if (sr_req_in && open_rows == 4'h0) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_REFRESH;
                  link.cke <= 1'b0;
                  st <= lpddr_seq_pkg::HOST_SR;
               end else if (pd_req_in) begin
                  link.cke <= 1'b0;
                  st <= lpddr_seq_pkg::HOST_PD;
               end else if (req_valid_in) begin
                  cmd_bits <= req_cmd_in;
                  link.ba <= req_bank_in;
                  link.addr <= req_addr_in;
                  if (req_cmd_in == lpddr_seq_pkg::CMD_ACTIVATE) begin
                     open_rows[req_bank_in] <= 1'b1;
                  end else if (req_cmd_in == lpddr_seq_pkg::CMD_PRECHARGE)
                  begin
                     open_rows <= req_addr_in[lpddr_seq_pkg::A10_BIT] ?
                        4'h0 : open_rows & ~(4'h1 << req_bank_in);
                  end
                  cnt <= 32'(REFRESH);
                  st <= lpddr_seq_pkg::HOST_WAIT;
               end
            end
            lpddr_seq_pkg::HOST_WAIT: begin
               if (cnt == 32'h0000_0001) begin
                  st <= lpddr_seq_pkg::HOST_IDLE;
               end
            end
            lpddr_seq_pkg::HOST_PD, lpddr_seq_pkg::HOST_SR: begin
               if (wake_in) begin
                  link.cke <= 1'b1;
                  cnt <= (st == lpddr_seq_pkg::HOST_SR) ?
                     32'(lpddr_seq_pkg::XSR_CYC) :
                     32'(lpddr_seq_pkg::PDX_CYC);
                  st <= lpddr_seq_pkg::HOST_WAIT;
               end
            end
            lpddr_seq_pkg::HOST_DPD: begin
               if (wake_in && cnt == 32'h0000_0000) begin
                  link.cke <= 1'b1;
                  cnt <= 32'(DPD_INIT);
                  st <= lpddr_seq_pkg::HOST_INIT_WAIT;
               end
            end
            lpddr_seq_pkg::HOST_INIT_WAIT: begin
               if (cnt == 32'h0000_0000) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_PRECHARGE;
                  link.addr <= 13'h0400;
                  cnt <= 32'h0000_0002;
                  refs <= 2'h0;
                  st <= lpddr_seq_pkg::HOST_INIT_REF;
               end
            end
            lpddr_seq_pkg::HOST_INIT_REF: begin
               if (cnt == 32'h0000_0000) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_REFRESH;
                  cnt <= 32'(REFRESH);
                  refs <= refs + 2'h1;
                  if (refs == 2'(lpddr_seq_pkg::INIT_REFRESHES - 1)) begin
                     st <= lpddr_seq_pkg::HOST_INIT_MODE;
                  end
               end
            end
            lpddr_seq_pkg::HOST_INIT_MODE: begin
               if (cnt == 32'h0000_0000) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_LOAD_MODE;
                  link.ba <= 2'h0;
                  cnt <= 32'h0000_0002;
                  st <= lpddr_seq_pkg::HOST_INIT_EMODE;
               end
            end
            lpddr_seq_pkg::HOST_INIT_EMODE: begin
               if (cnt == 32'h0000_0000) begin
                  cmd_bits <= lpddr_seq_pkg::CMD_LOAD_MODE;
                  link.ba <= 2'h2;
                  cnt <= 32'h0000_0002;
                  st <= lpddr_seq_pkg::HOST_WAIT;
               end
            end
            default: begin
               st <= lpddr_seq_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      link.cs_n = cmd_bits[3];
      link.ras_n = cmd_bits[2];
      link.cas_n = cmd_bits[1];
      link.we_n = cmd_bits[0];
      link.dm = 1'b1;
      req_ready_out = (st == lpddr_seq_pkg::HOST_IDLE) && !dpd_req_in &&
         !sr_req_in && !pd_req_in;
      busy_out = (st != lpddr_seq_pkg::HOST_IDLE);
   end
endmodule
`default_nettype wire

// ---- bench/lpddr_cmd_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpddr_cmd_properties #(
   parameter int DPD_MIN = 20,
   parameter int DPD_INIT = 30
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Command pins.
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [12:0] addr,
   input wire logic dm,
   // Device output enables.
   input wire logic dq_oe_n,
   input wire logic dqs_oe_n
);
   // Exit counts allow slack for where counting starts: one cycle for deep power-down, two for init.
   localparam int DPD_LOW = DPD_MIN - 1;
   localparam int INIT_LO = DPD_INIT - 2;
   logic [3:0] cmd;
   logic idle_cmd;
   logic rdwr;
   logic in_dpd;
   logic in_sr;
   logic init_on;
   int dpd_cnt;
   int init_cnt;
   assign cmd = cs_n ? 4'h8 : {1'b0, ras_n, cas_n, we_n};
   assign idle_cmd = cmd == 4'h8 || cmd == 4'h7;
   assign rdwr = cmd == 4'h5 || cmd == 4'h4;
   always_ff @(posedge clk_in) begin
      if (rst_in || cke) begin
         in_dpd <= 1'b0;
         in_sr <= 1'b0;
      end else begin
         in_dpd <= in_dpd || cmd == 4'h6;
         in_sr <= in_sr || cmd == 4'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      dpd_cnt <= (rst_in || !in_dpd) ? 0 : dpd_cnt + 1;
      init_cnt <= (rst_in || !init_on) ? 0 : init_cnt + 1;
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         init_on <= 1'b0;
      end else if (in_dpd && cke) begin
         init_on <= 1'b1;
      end else if (!idle_cmd) begin
         init_on <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_ref_quiet;
      cke && cmd == 4'h1 |=> (idle_cmd && cke) [*3];
   endproperty
   a_ref_quiet: assert property (p_ref_quiet)
      else $error("activity during refresh");
   property p_ref_float;
      cmd == 4'h1 |=> (dq_oe_n && dqs_oe_n) [*2];
   endproperty
   a_ref_float: assert property (p_ref_float)
      else $error("data driven during refresh");
   property p_read_mask; cke && cmd == 4'h5 |-> dm; endproperty
   a_read_mask: assert property (p_read_mask)
      else $error("read without mask");
   property p_pd_entry;
      $fell(cke) |-> !$past(rdwr) && !$past(rdwr, 2);
   endproperty
   a_pd_entry: assert property (p_pd_entry)
      else $error("clock enable drop during burst");
   property p_one_cycle; cke && !idle_cmd |=> idle_cmd; endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("command held too long");
   property p_dpd_stay; !cke && cmd == 4'h6 |=> !cke [*8]; endproperty
   a_dpd_stay: assert property (p_dpd_stay)
      else $error("deep power-down left at once");
   property p_dpd_hold; in_dpd && cke |-> dpd_cnt >= DPD_LOW; endproperty
   a_dpd_hold: assert property (p_dpd_hold)
      else $error("deep power-down too short");
   property p_exit_idle; $rose(cke) |-> idle_cmd; endproperty
   a_exit_idle: assert property (p_exit_idle)
      else $error("command on clock enable rise");
   property p_sr_exit; in_sr && cke |-> idle_cmd ##1 idle_cmd; endproperty
   a_sr_exit: assert property (p_sr_exit)
      else $error("command too soon after self refresh");
   property p_init_pre;
      init_on && !idle_cmd |-> init_cnt >= INIT_LO && cmd == 4'h2 && addr[10];
   endproperty
   a_init_pre: assert property (p_init_pre)
      else $error("bad first command after deep power-down");
   c_refresh: cover property (cke && cmd == 4'h1);
   c_dpd_exit: cover property (in_dpd && cke);
   c_sr_exit: cover property (in_sr && cke);
endmodule
`default_nettype wire

// ---- bench/lpddr_command_power_sequencing_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_power_sequencing_tb;
   localparam int DPD_MIN = 20;
   localparam int DPD_INIT = 30;
   localparam int REFRESH = 4;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   lpddr_seq_pkg::cmd_t req_cmd_in = lpddr_seq_pkg::CMD_NOP;
   logic [1:0] req_bank_in = 2'h0;
   logic [12:0] req_addr_in = 13'h0000;
   logic [3:0] ctl = 4'h0;
   logic [4:0] bbus = 5'h17;
   logic req_ready_out;
   logic busy_out;
   logic [2:0] pwr;
   logic [2:0] pwr_bad;
   logic [11:0] banks;
   logic [11:0] banks_bad;
   logic ill;
   logic early;
   logic ill_bad;
   logic early_bad;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 38606;
   int good_flags = 0;
   int bad_ill = 0;
   int bad_early = 0;
   lpddr_cmd_if u_lpddr_cmd_if ();
   lpddr_cmd_if u_lpddr_cmd_if_2 ();
   // The second link is driven by the bench to break the rules on purpose.
   assign {u_lpddr_cmd_if_2.cke, u_lpddr_cmd_if_2.cs_n, u_lpddr_cmd_if_2.ras_n,
      u_lpddr_cmd_if_2.cas_n, u_lpddr_cmd_if_2.we_n} = bbus;
   assign u_lpddr_cmd_if_2.ba = 2'h0;
   assign u_lpddr_cmd_if_2.addr = 13'h0000;
   assign u_lpddr_cmd_if_2.dm = 1'b1;
   lpddr_host_seq #(.DPD_MIN(DPD_MIN), .DPD_INIT(DPD_INIT), .REFRESH(REFRESH))
      u_lpddr_host_seq (.clk_in(clk_in), .rst_in(rst_in),
      .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
      .req_bank_in(req_bank_in), .req_addr_in(req_addr_in),
      .pd_req_in(ctl[0]), .sr_req_in(ctl[1]), .dpd_req_in(ctl[2]),
      .wake_in(ctl[3]), .req_ready_out(req_ready_out),
      .busy_out(busy_out), .link(u_lpddr_cmd_if));
   lpddr_device_seq #(.DPD_MIN(DPD_MIN), .REFRESH(REFRESH))
      u_lpddr_device_seq (
      .clk_in(clk_in), .rst_in(rst_in), .link(u_lpddr_cmd_if),
      .power_state_out(pwr), .bank_state_out(banks), .illegal_out(ill),
      .dpd_early_exit_out(early));
   lpddr_device_seq #(.DPD_MIN(DPD_MIN), .REFRESH(REFRESH))
      u_lpddr_device_seq_2 (.clk_in(clk_in), .rst_in(rst_in),
      .link(u_lpddr_cmd_if_2), .power_state_out(pwr_bad),
      .bank_state_out(banks_bad), .illegal_out(ill_bad),
      .dpd_early_exit_out(early_bad));
   lpddr_cmd_properties #(.DPD_MIN(DPD_MIN), .DPD_INIT(DPD_INIT))
      u_lpddr_cmd_properties (.clk_in(clk_in), .rst_in(rst_in),
      .cke(u_lpddr_cmd_if.cke), .cs_n(u_lpddr_cmd_if.cs_n),
      .ras_n(u_lpddr_cmd_if.ras_n), .cas_n(u_lpddr_cmd_if.cas_n),
      .we_n(u_lpddr_cmd_if.we_n), .addr(u_lpddr_cmd_if.addr),
      .dm(u_lpddr_cmd_if.dm), .dq_oe_n(u_lpddr_cmd_if.dq_oe_n),
      .dqs_oe_n(u_lpddr_cmd_if.dqs_oe_n));
   initial forever #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (ill === 1'b1 || early === 1'b1) good_flags++;
      if (ill_bad === 1'b1) bad_ill++;
      if (early_bad === 1'b1) bad_early++;
   end
   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk_val(string n, logic [11:0] e, logic [11:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk_cnt(string n, int e, int g);
      comparisons++;
      if (g != e) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", n, e, g);
      end
   endtask
   function automatic logic [2:0] st(bit bad, int f);
      if (f < 0) return bad ? pwr_bad : pwr;
      return bad ? banks_bad[3*f +: 3] : banks[3*f +: 3];
   endfunction
   function automatic logic [2:0] exp_bank(logic ap);
      return ap ? lpddr_seq_pkg::BANK_IDLE : lpddr_seq_pkg::BANK_ACTIVE;
   endfunction
   // States are polled on the falling edge, where registered outputs settle.
   task wait_st(bit bad, int f, logic [2:0] e);
      int i;
      @(negedge clk_in);
      for (i = 0; i < 300 && st(bad, f) !== e; i++) @(negedge clk_in);
      chk_val(f < 0 ? "power" : "bank", {9'h000, e}, {9'h000, st(bad, f)});
   endtask
   task idle_wait;
      int i;
      @(negedge clk_in);
      for (i = 0; i < 400 && !(busy_out === 1'b0 && req_ready_out === 1'b1);
         i++) @(negedge clk_in);
      chk_val("ready", 12'h001, {10'h000, busy_out, req_ready_out});
   endtask
   task send(lpddr_seq_pkg::cmd_t c, logic [1:0] b, logic [12:0] a);
      idle_wait();
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_cmd_in <= c;
      req_bank_in <= b;
      req_addr_in <= a;
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task pulse(logic [3:0] m);
      // The host hears power requests only while it sits idle.
      idle_wait();
      @(posedge clk_in);
      ctl <= m;
      @(posedge clk_in);
      ctl <= 4'h0;
   endtask
   task wake(logic [2:0] e);
      @(posedge clk_in);
      ctl <= 4'h8;
      wait_st(0, -1, e);
      @(posedge clk_in);
      ctl <= 4'h0;
   endtask
   task bcmd(logic k, logic [3:0] c, logic k2);
      @(posedge clk_in);
      bbus <= {k, c};
      @(posedge clk_in);
      bbus <= {k2, 4'h7};
   endtask
   initial begin
      #(8 * 30000);
      mismatches++;
      give_verdict();
   end
   initial begin
      logic [1:0] b;
      logic ap;
      logic [9:0] col;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int n = 0; n < 8; n++) begin
         b = 2'($random(seed));
         ap = 1'($random(seed));
         col = 10'($random(seed));
         send(lpddr_seq_pkg::CMD_ACTIVATE, b, {3'h0, col});
         wait_st(0, b, lpddr_seq_pkg::BANK_ACTIVE);
         send(col[0] ? lpddr_seq_pkg::CMD_READ : lpddr_seq_pkg::CMD_WRITE, b,
            {2'h0, ap, col});
         wait_st(0, b, exp_bank(ap));
         if (!ap) send(lpddr_seq_pkg::CMD_PRECHARGE, b, 13'h0000);
         wait_st(0, b, lpddr_seq_pkg::BANK_IDLE);
      end
      send(lpddr_seq_pkg::CMD_ACTIVATE, 2'h0, 13'h0000);
      send(lpddr_seq_pkg::CMD_ACTIVATE, 2'h3, 13'h0000);
      pulse(4'h1);
      wait_st(0, -1, lpddr_seq_pkg::PWR_ACT_PD);
      wake(lpddr_seq_pkg::PWR_ON);
      pulse(4'h2);
      repeat (10) @(negedge clk_in);
      chk_val("power", 12'h000, {9'h000, pwr});
      send(lpddr_seq_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
      wait_st(0, 3, lpddr_seq_pkg::BANK_IDLE);
      chk_val("banks", 12'h000, banks);
      pulse(4'h1);
      wait_st(0, -1, lpddr_seq_pkg::PWR_PRE_PD);
      wake(lpddr_seq_pkg::PWR_ON);
      send(lpddr_seq_pkg::CMD_REFRESH, 2'h0, 13'h0000);
      wait_st(0, -1, lpddr_seq_pkg::PWR_REFRESHING);
      wait_st(0, -1, lpddr_seq_pkg::PWR_ON);
      send(lpddr_seq_pkg::CMD_LOAD_MODE, 2'h0, 13'h0000);
      pulse(4'h2);
      wait_st(0, -1, lpddr_seq_pkg::PWR_SELF_REFRESH);
      wake(lpddr_seq_pkg::PWR_ON);
      pulse(4'h4);
      wait_st(0, -1, lpddr_seq_pkg::PWR_DEEP_PD);
      wake(lpddr_seq_pkg::PWR_ON);
      idle_wait();
      chk_val("banks", 12'h000, banks);
      chk_cnt("flags", 0, good_flags);
      bcmd(1'b1, 4'h3, 1'b1);
      wait_st(1, 0, lpddr_seq_pkg::BANK_ACTIVE);
      bcmd(1'b1, 4'h5, 1'b0);
      bcmd(1'b1, 4'h7, 1'b1);
      bcmd(1'b1, 4'h1, 1'b1);
      repeat (3) @(posedge clk_in);
      chk_cnt("illegal", 2, bad_ill);
      wait_st(1, -1, lpddr_seq_pkg::PWR_ON);
      bcmd(1'b1, 4'h2, 1'b1);
      wait_st(1, 0, lpddr_seq_pkg::BANK_IDLE);
      bcmd(1'b1, 4'h1, 1'b0);
      bcmd(1'b1, 4'h7, 1'b1);
      repeat (3) @(posedge clk_in);
      chk_cnt("illegal", 3, bad_ill);
      wait_st(1, -1, lpddr_seq_pkg::PWR_ON);
      bcmd(1'b0, 4'h6, 1'b0);
      wait_st(1, -1, lpddr_seq_pkg::PWR_DEEP_PD);
      bcmd(1'b1, 4'h7, 1'b1);
      repeat (3) @(posedge clk_in);
      chk_cnt("early", 1, bad_early);
      wait_st(1, -1, lpddr_seq_pkg::PWR_ON);
      give_verdict();
   end
endmodule
`default_nettype wire
